// File: rtl/drs_pkg.sv
// drs_pkg: constants and types for the dma request/sequencing core.
// assumes a single 125 MHz system clock; register map over a plain port.
package drs_pkg;
	localparam int NCH = 4;
	localparam int CNT_W = 16;
	// register offsets: per channel control at 0x00..0x03, count 0x04..0x07
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_COUNT0 = 8'h04;
	localparam logic [7:0] ADDR_OPCTL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h09;
	// channel control field positions
	localparam int CC_ENABLE = 0;
	localparam int CC_IRQEN = 1;
	localparam int CC_TEND = 2;
	localparam int CC_BURST = 3;
	localparam int CC_EDGE = 4;
	localparam int CC_DUAL = 5;
	localparam int CC_SRC_LO = 6;
	localparam int CC_SRC_W = 2;
	// request sources
	localparam logic [1:0] SRC_AUTO = 2'h0;
	localparam logic [1:0] SRC_EXT = 2'h1;
	localparam logic [1:0] SRC_PERI = 2'h2;
	localparam logic [1:0] SRC_SERIAL = 2'h3;
	// operation control fields
	localparam int OC_MASTER = 0;
	localparam int OC_NMI = 1;
	localparam int OC_AERR = 2;
	localparam int OC_PRIO_LO = 3;
	// wait states for dma cycles, dual and single address
	localparam logic [3:0] WAIT_DUAL_RST = 4'h1;
	localparam logic [3:0] WAIT_SINGLE_RST = 4'h0;
	// least gap from request detection to dma bus cycle, in states
	localparam int REQ_TO_CYCLE_STATES = 2;
	localparam logic [1:0] REQ_DELAY = 2'(REQ_TO_CYCLE_STATES);
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OPCTL_RST = 8'h00;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_READ = 3'b011,
		ST_WRITE = 3'b010,
		ST_DONE = 3'b110
	} drs_state_e;
endpackage

// File: rtl/drs_core.sv
// drs_core: four-channel dma request sampling, arbitration and termination.
// assumes the bus grants at once; one state is one clock.
// Operation
// (RL1) serial source forces cycle-steal mode
// (RL2) external pin requests only on channels 0,1
// (RL3) software avoids serial source without peripheral
// (RL4) serial-triggered channel must touch serial register
// (RL5) higher channel preempts running burst immediately
// (RL6) burst preemptor finishes before lower resumes
// (RL7) cycle-steal preemptor alternates unit by unit
// (RL8) active burst never releases bus to cpu
// (RL9) cycle length from dual or single wait
// (RL10) sample request pin, cycle two states later
// (RL11) edge mode resamples only after next edge
// (RL12) resample third state after preceding cycle
// (RL13) miss: sample ack state, then every state
// (RL14) burst edge runs to end, then samples
// (RL15) burst level resamples per bus/read cycle
// (RL16) count zero sets end flag, interrupt
// (RL17) clearing channel enable halts, no end flag
// (RL18) nmi/address error halt all, flag set
// (RL19) resume: clear halt flag, set enable
// (RL20) dual read error completes write first
// (RL21) master enable clear aborts after cycle
// (RL22) cycle-steal releases bus after each unit
// (RL23) burst keeps bus until end condition
// (RL24) acknowledge only during serving dma cycle
// (RL25) simultaneous requests go to highest priority
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module drs_core
	import drs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdData,
	input wire logic [1:0] transferRequestN,
	input wire logic [NCH-1:0] periRequest,
	input wire logic nmiEvent,
	input wire logic busAddrError,
	output logic [1:0] transferAcknowledge,
	output logic busRequest,
	output logic [1:0] dmaChannel,
	output logic dmaReadCycle,
	output logic dmaWriteCycle,
	output logic transferEndInterrupt
);
	logic [7:0] ctrl_r [NCH];
	logic [CNT_W-1:0] count_r [NCH];
	logic [7:0] opctl_r;
	logic [3:0] waitDual_r, waitSingle_r;
	logic [1:0] reqMeta_r, reqSync_r, reqPrev_r;
	logic [NCH-1:0] pend_r;
	logic [1:0] sampleMode_r [2];
	drs_state_e state_r;
	logic [1:0] cur_r;
	logic [3:0] waitCnt_r;
	logic [1:0] dly_r;
	logic errPending_r;
	logic [NCH-1:0] want, enOk, burstCh, endIrq;
	logic [1:0] winner, nextCh;
	logic haltAll, anyWant, cycEnd, unitDone, holdBus;

	// channel selected by fixed or rotating-free priority order
	function automatic logic [1:0] prioPick(input logic [NCH-1:0] w,
		input logic rot);
		logic [1:0] p;
		// channel 0 ranks first in both orders
		if (w[0])
			p = 2'h0;
		else if (rot)
			p = w[3] ? 2'h3 : (w[2] ? 2'h2 : (w[1] ? 2'h1 : 2'h0));
		else
			p = w[1] ? 2'h1 : (w[2] ? 2'h2 : (w[3] ? 2'h3 : 2'h0));
		return p;
	endfunction

	function automatic logic isBurst(input logic [7:0] c);
		// serial-port source never allowed to burst, see (RL1)
		return c[CC_BURST] && (c[CC_SRC_LO +: CC_SRC_W] != SRC_SERIAL);
	endfunction

	assign haltAll = !opctl_r[OC_MASTER] || opctl_r[OC_NMI]
		|| opctl_r[OC_AERR];

	// a channel may run if enabled, not ended, not halted
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gen_ch
			assign enOk[g] = ctrl_r[g][CC_ENABLE] && !ctrl_r[g][CC_TEND]
				&& !haltAll && (count_r[g] != '0);
			assign want[g] = enOk[g] && pend_r[g];
			assign burstCh[g] = isBurst(ctrl_r[g]);
			assign endIrq[g] = ctrl_r[g][CC_TEND] && ctrl_r[g][CC_IRQEN];
		end
	endgenerate

	assign anyWant = |want;
	// highest ranked requester, see (RL25)
	assign winner = prioPick(want, opctl_r[OC_PRIO_LO]);
	// after a steal unit a waiting burst channel goes next, see (RL7)
	assign nextCh = (!burstCh[cur_r] && |(want & burstCh))
		? prioPick(want & burstCh, opctl_r[OC_PRIO_LO]) : winner;

	// request pin synchroniser, first stage read only by second
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reqMeta_r <= 2'h3;
			reqSync_r <= 2'h3;
			reqPrev_r <= 2'h3;
		end
		else
		begin
			reqMeta_r <= transferRequestN;
			reqSync_r <= reqMeta_r;
			reqPrev_r <= reqSync_r;
		end
	end

	// end of a dma bus cycle
	assign cycEnd = (state_r == ST_READ || state_r == ST_WRITE)
		&& waitCnt_r == 4'h0;
	assign unitDone = cycEnd && (state_r == ST_WRITE
		|| !ctrl_r[cur_r][CC_DUAL]);

	// pending requests and pin sampling policy
	// sampleMode: 0 every state, 1 wait ack state, 2 blocked till end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_r <= '0;
			sampleMode_r[0] <= 2'h0;
			sampleMode_r[1] <= 2'h0;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				logic [1:0] s;
				logic lvl;
				logic edg;
				logic smp;
				s = ctrl_r[c][CC_SRC_LO +: CC_SRC_W];
				lvl = 1'b0;
				edg = 1'b0;
				smp = 1'b1;
				if (c < 2)
				begin
					lvl = !reqSync_r[c];
					edg = reqPrev_r[c] && !reqSync_r[c];
					smp = sampleMode_r[c] == 2'h0
						|| (sampleMode_r[c] == 2'h1 && cycEnd && cur_r == c);
				end
				if (!enOk[c])
					pend_r[c] <= 1'b0;
				else if (s == SRC_AUTO)
					pend_r[c] <= 1'b1;
				else if (s == SRC_PERI || s == SRC_SERIAL)
					pend_r[c] <= periRequest[c] || (pend_r[c]
						&& !(unitDone && cur_r == c));
				else if (c < 2)
				begin
					// external pin serves only 0 and 1, see (RL2)
					if (ctrl_r[c][CC_EDGE])
					begin
						// edge captured once, no resample, see (RL11)
						if (edg && smp)
							pend_r[c] <= 1'b1;
						else if (unitDone && cur_r == c
							&& !isBurst(ctrl_r[c]))
							pend_r[c] <= 1'b0;
					end
					else if (smp)
						// level sampled at allowed points, see (RL10)
						pend_r[c] <= lvl;
				end
				else
					pend_r[c] <= 1'b0;
			end
			for (int c = 0; c < 2; c++)
			begin
				if (!enOk[c])
					// after end, sample every state, see (RL14)
					sampleMode_r[c] <= 2'h0;
				else if (pend_r[c] && isBurst(ctrl_r[c])
					&& ctrl_r[c][CC_EDGE])
					// burst edge: no sampling till end, see (RL14)
					sampleMode_r[c] <= 2'h2;
				else if (pend_r[c])
					// burst level per cycle, steal at ack state,
					// see (RL12) (RL15)
					sampleMode_r[c] <= 2'h1;
				else if (sampleMode_r[c] == 2'h1 && cycEnd)
					// missed sample, fall back, see (RL13)
					sampleMode_r[c] <= 2'h0;
			end
		end
	end

	// transfer sequencer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= ST_IDLE;
			cur_r <= 2'h0;
			waitCnt_r <= 4'h0;
			dly_r <= 2'h0;
			errPending_r <= 1'b0;
		end
		else
		begin
			case (state_r)
			ST_IDLE:
			begin
				if (anyWant)
				begin
					// cycle no earlier than two states, see (RL10)
					cur_r <= winner;
					dly_r <= REQ_DELAY - 2'h1;
					state_r <= ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (!enOk[cur_r])
					state_r <= ST_IDLE;
				else if (dly_r != 2'h0)
					dly_r <= dly_r - 2'h1;
				else
				begin
					// wait count from the address mode, see (RL9)
					waitCnt_r <= ctrl_r[cur_r][CC_DUAL] ? waitDual_r
						: waitSingle_r;
					state_r <= ST_READ;
				end
			end
			ST_READ:
			begin
				if (waitCnt_r != 4'h0)
					waitCnt_r <= waitCnt_r - 4'h1;
				else if (ctrl_r[cur_r][CC_DUAL])
				begin
					// read error still completes write, see (RL20)
					errPending_r <= busAddrError;
					waitCnt_r <= waitDual_r;
					state_r <= ST_WRITE;
				end
				else
					state_r <= ST_DONE;
			end
			ST_WRITE:
			begin
				errPending_r <= errPending_r || busAddrError;
				if (waitCnt_r != 4'h0)
					waitCnt_r <= waitCnt_r - 4'h1;
				else
					state_r <= ST_DONE;
			end
			ST_DONE:
			begin
				errPending_r <= 1'b0;
				if (!anyWant)
					state_r <= ST_IDLE;
				else
				begin
					// higher wins at once, burst preemptor runs to
					// its end, see (RL5) (RL6)
					cur_r <= nextCh;
					waitCnt_r <= ctrl_r[nextCh][CC_DUAL] ? waitDual_r
						: waitSingle_r;
					state_r <= ST_READ;
				end
			end
			default:
				state_r <= ST_IDLE;
			endcase
			// master clear aborts at cycle end, see (RL21)
			if (haltAll && (state_r == ST_IDLE || state_r == ST_WAIT
				|| state_r == ST_DONE))
				state_r <= ST_IDLE;
			// channel disable stops its transfer, see (RL17)
			else if (state_r == ST_DONE && !ctrl_r[cur_r][CC_ENABLE])
				state_r <= ST_IDLE;
		end
	end

	// bus ownership: burst holds bus, steal releases, see (RL8)
	// see (RL22) (RL23)
	always_comb
	begin
		holdBus = state_r != ST_IDLE;
		if (state_r == ST_DONE && !burstCh[cur_r]
			&& !(|(want & burstCh)))
			holdBus = 1'b0;
	end

	// acknowledge and cycle qualifiers only in serving cycle, see (RL24)
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			transferAcknowledge <= 2'h0;
			busRequest <= 1'b0;
			dmaChannel <= 2'h0;
			dmaReadCycle <= 1'b0;
			dmaWriteCycle <= 1'b0;
		end
		else
		begin
			// bus flag lags with the cycle flags, so ack never outlives it
			busRequest <= holdBus;
			dmaChannel <= cur_r;
			dmaReadCycle <= state_r == ST_READ;
			dmaWriteCycle <= state_r == ST_WRITE;
			transferAcknowledge <= 2'h0;
			if ((state_r == ST_READ || state_r == ST_WRITE) && !cur_r[1])
				transferAcknowledge[cur_r[0]] <= 1'b1;
		end
	end

	// registers: software writes, hardware count, end and halt flags
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				ctrl_r[c] <= CTRL_RST;
				count_r[c] <= '0;
			end
			opctl_r <= OPCTL_RST;
			waitDual_r <= WAIT_DUAL_RST;
			waitSingle_r <= WAIT_SINGLE_RST;
		end
		else
		begin
			if (regWrite)
			begin
				if (regAddr >= ADDR_CTRL0 && regAddr < ADDR_COUNT0)
					ctrl_r[regAddr[1:0]] <= regWrData[7:0];
				else if (regAddr >= ADDR_COUNT0 && regAddr < ADDR_OPCTL)
					count_r[regAddr[1:0]] <= regWrData;
				else if (regAddr == ADDR_OPCTL)
					// halt flags clear only by software, see (RL19)
					opctl_r <= regWrData[7:0];
				else if (regAddr == ADDR_STATUS)
				begin
					waitDual_r <= regWrData[3:0];
					waitSingle_r <= regWrData[7:4];
				end
			end
			// count update and end flag on last unit, see (RL16)
			if (unitDone)
			begin
				count_r[cur_r] <= count_r[cur_r] - 16'h0001;
				if (count_r[cur_r] == 16'h0001)
					ctrl_r[cur_r][CC_TEND] <= 1'b1;
			end
			// halts win over clearing write, see (RL18)
			if (nmiEvent)
				opctl_r[OC_NMI] <= 1'b1;
			if ((busAddrError && state_r == ST_READ
				&& !ctrl_r[cur_r][CC_DUAL]) || (unitDone
				&& (errPending_r || busAddrError)))
				opctl_r[OC_AERR] <= 1'b1;
		end
	end

	// end interrupt from enabled end flags, see (RL16)
	assign transferEndInterrupt = |endIrq;

	// read data one cycle after the read strobe
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			regRdData <= 16'h0000;
		else if (regRead)
		begin
			if (regAddr >= ADDR_CTRL0 && regAddr < ADDR_COUNT0)
				regRdData <= {8'h00, ctrl_r[regAddr[1:0]]};
			else if (regAddr >= ADDR_COUNT0 && regAddr < ADDR_OPCTL)
				regRdData <= count_r[regAddr[1:0]];
			else if (regAddr == ADDR_OPCTL)
				regRdData <= {8'h00, opctl_r};
			else if (regAddr == ADDR_STATUS)
				regRdData <= {8'h00, waitSingle_r, waitDual_r};
			else
				regRdData <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// File: tb/drs_core_assertions.sv
// drs_core_chk: port-level assertions for drs_core.
// assumes one clock, reset asynchronous and active low.
`timescale 1ns/10ps
`default_nettype none
module drs_core_chk
	import drs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regRdData,
	input wire logic [1:0] transferRequestN,
	input wire logic [NCH-1:0] periRequest,
	input wire logic nmiEvent,
	input wire logic busAddrError,
	input wire logic [1:0] transferAcknowledge,
	input wire logic busRequest,
	input wire logic [1:0] dmaChannel,
	input wire logic dmaReadCycle,
	input wire logic dmaWriteCycle,
	input wire logic transferEndInterrupt
);
	logic [3:0] sinceCyc_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// states since the last dma cycle, saturating
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			sinceCyc_r <= 4'hF;
		else if (dmaReadCycle || dmaWriteCycle)
			sinceCyc_r <= 4'h0;
		else if (sinceCyc_r != 4'hF)
			sinceCyc_r <= sinceCyc_r + 4'h1;
	property p_ackBus;
		|transferAcknowledge |-> busRequest;
	endproperty
	a_ackBus: assert property (p_ackBus)
		else $error("acknowledge without bus");
	property p_ackCh;
		transferAcknowledge != 2'b00 |-> !dmaChannel[1] &&
			transferAcknowledge == (2'b01 << dmaChannel[0]);
	endproperty
	a_ackCh: assert property (p_ackCh)
		else $error("acknowledge on wrong channel");
	property p_cycBus;
		dmaReadCycle || dmaWriteCycle |->
			busRequest && !(dmaReadCycle && dmaWriteCycle);
	endproperty
	a_cycBus: assert property (p_cycBus)
		else $error("dma cycle without bus");
	property p_reqGap;
		$fell(transferRequestN[0]) && !busRequest |->
			!transferAcknowledge[0] [*3];
	endproperty
	a_reqGap: assert property (p_reqGap)
		else $error("acknowledge too soon after request");
	property p_tend;
		$rose(transferEndInterrupt) && !$past(regWrite) |->
			sinceCyc_r <= 4'h4;
	endproperty
	a_tend: assert property (p_tend)
		else $error("end interrupt without a transfer");
	property p_nmi;
		nmiEvent |-> ##[0:12] !busRequest;
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("bus kept after nmi");
	property p_master;
		regWrite && regAddr == ADDR_OPCTL && !regWrData[OC_MASTER] |->
			##[0:12] !busRequest;
	endproperty
	a_master: assert property (p_master)
		else $error("bus kept after master clear");
	property p_rdHold;
		!$past(regRead) |-> $stable(regRdData);
	endproperty
	a_rdHold: assert property (p_rdHold)
		else $error("read data moved without read");
endmodule
bind drs_core drs_core_chk chk (.clk, .arst_n, .regAddr, .regWrData,
	.regWrite, .regRead, .regRdData, .transferRequestN, .periRequest,
	.nmiEvent, .busAddrError, .transferAcknowledge, .busRequest,
	.dmaChannel, .dmaReadCycle, .dmaWriteCycle, .transferEndInterrupt);
`default_nettype wire

// File: tb/drs_peer.sv
// drs_peer: external requester on one request pin, level style.
// assumes acknowledge rises once for each served unit.
`timescale 1ns/10ps
`default_nettype none
module drs_peer
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic load,
	input wire logic [3:0] units,
	input wire logic ack,
	output logic reqN,
	output logic [3:0] seen
);
	logic [3:0] left_r;
	logic ack_r;
	// pin low while units remain, pulled high once idle
	assign reqN = (left_r == 4'h0);
	// every rising acknowledge counted, extra ones too
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			left_r <= 4'h0;
			seen <= 4'h0;
			ack_r <= 1'b0;
		end
		else
		begin
			ack_r <= ack;
			if (load)
				left_r <= units;
			else if (ack && !ack_r && left_r != 4'h0)
				left_r <= left_r - 4'h1;
			if (load)
				seen <= 4'h0;
			else if (ack && !ack_r)
				seen <= seen + 4'h1;
		end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking bench for drs_core.
// assumes drs_peer requesting on pin 0; pin 1 idle.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import drs_pkg::*;
;
	logic clk, arstN, regWrite, regRead, nmiEvent, busAddrError, load;
	logic [7:0] regAddr;
	logic [15:0] regWrData, regRdData;
	logic [1:0] transferAcknowledge, dmaChannel;
	logic [NCH-1:0] periRequest;
	logic busRequest, dmaReadCycle, dmaWriteCycle, transferEndInterrupt;
	logic peerReqN, busQ;
	logic [3:0] seen;
	wire [1:0] transferRequestN = {1'b1, peerReqN};
	int mismatches, cmp_count, cyc, rises, base;
	logic [15:0] rstVal [0:10] = '{9: {8'h00, WAIT_SINGLE_RST,
		WAIT_DUAL_RST}, default: 16'h0000};
	drs_core dut
	(
		.clk, .arst_n(arstN), .regAddr, .regWrData, .regWrite, .regRead,
		.regRdData, .transferRequestN, .periRequest, .nmiEvent,
		.busAddrError, .transferAcknowledge, .busRequest, .dmaChannel,
		.dmaReadCycle, .dmaWriteCycle, .transferEndInterrupt
	);
	drs_peer peer
	(
		.clk, .arst_n(arstN), .load, .units(4'h2),
		.ack(transferAcknowledge[0]), .reqN(peerReqN), .seen
	);
	task automatic close_out;
		$display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] e);
		cmp_count++;
		if (got !== e)
		begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	// strobes start on an edge; the lead-in edge keeps calls apart
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regRdData, e);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 400 && s !== 1'b1; i++)
			@(posedge clk) #1;
	endtask
	// free-running 8 ns clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// bus grant counter and hang guard
	always @(posedge clk)
	begin
		busQ <= busRequest;
		rises <= rises + int'(busRequest && !busQ);
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			close_out();
		end
	end
	initial
	begin
		arstN = 1'b0;
		{regWrite, regRead, nmiEvent, busAddrError, load} = '0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		periRequest = '0;
		repeat (3) @(posedge clk);
		arstN <= 1'b1;
		// reset values, 0x0A unmapped
		for (int i = 0; i <= 10; i++)
			rd(8'(i), rstVal[i]);
		// two external units on channel 0, cycle steal
		wr(ADDR_COUNT0, 16'h0002);
		wr(ADDR_CTRL0, 16'h0043);
		wr(ADDR_OPCTL, 16'h0001);
		@(posedge clk);
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		wait_hi(transferEndInterrupt);
		chk(16'(transferEndInterrupt), 16'h0001);
		rd(ADDR_CTRL0, 16'h0047);
		rd(ADDR_COUNT0, 16'h0000);
		chk(16'(seen), 16'h0002);
		wr(ADDR_CTRL0, 16'h0000);
		settle(1);
		chk(16'(transferEndInterrupt), 16'h0000);
		// channels 1 and 2 released together, both orders
		for (int p = 0; p < 2; p++)
		begin
			wr(ADDR_OPCTL, 16'h0000);
			wr(ADDR_COUNT0 + 8'h01, 16'h0001);
			wr(ADDR_COUNT0 + 8'h02, 16'h0001);
			wr(ADDR_CTRL0 + 8'h01, 16'h0001);
			wr(ADDR_CTRL0 + 8'h02, 16'h0001);
			wr(ADDR_OPCTL, p ? 16'h0009 : 16'h0001);
			wait_hi(dmaReadCycle);
			chk(16'(dmaChannel), p ? 16'h0002 : 16'h0001);
			settle(40);
			wr(ADDR_CTRL0 + 8'h01, 16'h0000);
			wr(ADDR_CTRL0 + 8'h02, 16'h0000);
		end
		// burst on channel 3 halted by nmi, resumed, then aborted
		wr(ADDR_COUNT0 + 8'h03, 16'h0080);
		wr(ADDR_CTRL0 + 8'h03, 16'h0009);
		wr(ADDR_OPCTL, 16'h0001);
		wait_hi(busRequest);
		nmiEvent <= 1'b1;
		@(posedge clk);
		nmiEvent <= 1'b0;
		settle(12);
		chk(16'(busRequest), 16'h0000);
		rd(ADDR_OPCTL, 16'h0003);
		rd(ADDR_CTRL0 + 8'h03, 16'h0009);
		wr(ADDR_CTRL0 + 8'h03, 16'h0008);
		wr(ADDR_OPCTL, 16'h0001);
		settle(12);
		chk(16'(busRequest), 16'h0000);
		wr(ADDR_CTRL0 + 8'h03, 16'h0009);
		wait_hi(busRequest);
		chk(16'(busRequest), 16'h0001);
		wr(ADDR_OPCTL, 16'h0000);
		settle(12);
		chk(16'(busRequest), 16'h0000);
		rd(ADDR_CTRL0 + 8'h03, 16'h0009);
		// serial source with burst bit still gives one grant a unit
		wr(ADDR_CTRL0 + 8'h03, 16'h0000);
		wr(ADDR_COUNT0 + 8'h03, 16'h0003);
		wr(ADDR_CTRL0 + 8'h03, 16'h00CB);
		base = rises;
		periRequest <= 4'h8;
		wr(ADDR_OPCTL, 16'h0001);
		wait_hi(transferEndInterrupt);
		// last grant is counted one edge after the end flag
		settle(2);
		chk(16'(rises - base), 16'h0003);
		periRequest <= 4'h0;
		close_out();
	end
endmodule
`default_nettype wire
